/* File: common/drgc_map.svh */
// register layout, reset values and code constants for the dac reference and gain control
`ifndef DRGC_MAP_SVH
`define DRGC_MAP_SVH
`define DRGC_REF_SUPPLY 2'h0
`define DRGC_REF_BANDGAP 2'h1
`define DRGC_REF_PIN_UNBUF 2'h2
`define DRGC_REF_PIN_BUF 2'h3
`define DRGC_GAIN0_POS 8
`define DRGC_GAIN1_POS 9
`define DRGC_GS_WIDTH 16
`define DRGC_PD_NORMAL 2'h0
`define DRGC_RST_REF 2'h0
`define DRGC_RST_GAIN 1'h0
`define DRGC_RST_CODE 12'h000
`define DRGC_RST_PD 2'h0
`define DRGC_CODE_BITS 12
`define DRGC_LADDER_8BIT 16'h0100
`define DRGC_LADDER_10BIT 16'h0400
`define DRGC_LADDER_12BIT 16'h1000
`endif

/* File: common/drgc_pkg.sv */
// types for the dac reference and gain control
package drgc_pkg;
  typedef struct packed {
    logic [1:0] ref_source_select;
    logic gain_bit;
    logic [1:0] powerdown_select;
    logic [11:0] code;
  } drgc_chan_cfg_t;

  typedef struct packed {
    logic [3:0] ladder_top_node;
    logic amp_gain2;
    logic amp_enable;
    logic out_hiz;
    logic [11:0] wiper_code;
  } drgc_chan_ctl_t;
endpackage : drgc_pkg

/* File: src/drgc_core.sv */
// reference selection, gain and output enable control for one or two dac channels
`timescale 1ns/1ps
`include "drgc_map.svh"

// What this block does
// - two select bits pick one ladder source
// - code 00 selects the supply reference
// - applied source comes from volatile select copy
// - power-on or brown-out loads stored select bits
// - supply selected keeps reference pin disconnected
// - gain bit zero unity, one double
// - supply reference forces unity gain always
// - double gain only with pin or bandgap
// - any power-down turns amplifier off, hiz
// - gain changes only on reset, write, call
// - code is unsigned, scaled by ladder count
// - ladder count follows resolution variant
// - writes take effect at acknowledge falling edge
// - general call reset reloads stored settings
// - channel gains sit at bits eight, nine
module drgc_core import drgc_pkg::*; #(
  parameter int CHANNELS = 2,
  parameter int RES_BITS = 12
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // stored power-on values per channel
  input drgc_chan_cfg_t [CHANNELS-1:0] nv_cfg,
  // pending write from the serial port, committed at ack fall
  input wire logic wr_valid,
  input wire logic [CHANNELS-1:0] wr_chan,
  input drgc_chan_cfg_t wr_cfg,
  input wire logic ack_fall,
  input wire logic gencall_reset,
  // control toward the analog section
  output drgc_chan_ctl_t [CHANNELS-1:0] chan_ctl,
  output logic [`DRGC_GS_WIDTH-1:0] gain_status,
  output logic [15:0] ladder_count
);

  typedef struct packed {
    drgc_chan_cfg_t [CHANNELS-1:0] vol;
    drgc_chan_ctl_t [CHANNELS-1:0] ctl;
    logic [`DRGC_GS_WIDTH-1:0] gs;
    logic [15:0] lcount;
    logic loaded;
  } drgc_state_t;

  drgc_state_t st_q;
  drgc_state_t st_d;

  // one-hot ladder switch for a select code; supply leaves the pin open
  function automatic logic [3:0] drgc_src_onehot(input logic [1:0] sel);
    logic [3:0] oh;
    oh = 4'h0;
    if (sel == `DRGC_REF_SUPPLY) begin
      oh = 4'h1;
    end else if (sel == `DRGC_REF_BANDGAP) begin
      oh = 4'h2;
    end else if (sel == `DRGC_REF_PIN_UNBUF) begin
      oh = 4'h4;
    end else begin
      oh = 4'h8;
    end
    return oh;
  endfunction : drgc_src_onehot

  // double gain needs a non-supply source; the stored bit alone is not enough
  function automatic logic drgc_gain2(input logic [1:0] sel, input logic gain);
    logic g2;
    g2 = 1'b0;
    if (gain && (sel != `DRGC_REF_SUPPLY)) begin
      g2 = 1'b1;
    end
    return g2;
  endfunction : drgc_gain2

  // next state: reload, commit, then derive control from the volatile copy
  always_comb begin
    st_d = st_q;
    if (!st_q.loaded || gencall_reset) begin
      st_d.vol = nv_cfg;
      st_d.loaded = 1'b1;
    end else if (wr_valid && ack_fall) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (wr_chan[i]) begin
          st_d.vol[i] = wr_cfg;
        end
      end
    end
    st_d.gs = '0;
    st_d.lcount = 16'(1 << RES_BITS);
    for (int i = 0; i < CHANNELS; i++) begin
      st_d.ctl[i].ladder_top_node = drgc_src_onehot(st_d.vol[i].ref_source_select);
      // supply reference ignores the stored gain bit
      st_d.ctl[i].amp_gain2 = drgc_gain2(st_d.vol[i].ref_source_select, st_d.vol[i].gain_bit);
      st_d.ctl[i].amp_enable = (st_d.vol[i].powerdown_select == `DRGC_PD_NORMAL);
      st_d.ctl[i].out_hiz = (st_d.vol[i].powerdown_select != `DRGC_PD_NORMAL);
      // left-justified unsigned code; low bits unused on narrow variants
      st_d.ctl[i].wiper_code = st_d.vol[i].code;
      st_d.gs[`DRGC_GAIN0_POS + i] = st_d.vol[i].gain_bit;
    end
  end

  // state register; reset means power-on or brown-out
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign chan_ctl = st_q.ctl;
  assign gain_status = st_q.gs;
  assign ladder_count = st_q.lcount;

  // checks
  for (genvar g = 0; g < CHANNELS; g++) begin : g_chk
    chk_supply_unity: assert property (@(posedge clock) disable iff (sys_rst)
      (st_q.ctl[g].ladder_top_node[0] |-> !st_q.ctl[g].amp_gain2))
      else $error("gain two with supply reference");
    chk_onehot_src: assert property (@(posedge clock) disable iff (sys_rst)
      st_q.loaded |-> $onehot(st_q.ctl[g].ladder_top_node))
      else $error("ladder source not one-hot");
    chk_pd_hiz: assert property (@(posedge clock) disable iff (sys_rst)
      st_q.loaded |-> (st_q.ctl[g].out_hiz == (st_q.vol[g].powerdown_select != `DRGC_PD_NORMAL)))
      else $error("power-down output not high impedance");
    chk_gain_stable: assert property (@(posedge clock) disable iff (sys_rst)
      (st_q.loaded && clk_en && !gencall_reset && !(wr_valid && ack_fall && wr_chan[g]))
      |=> $stable(st_q.vol[g].gain_bit))
      else $error("gain bit changed without cause");
    chk_write_commit: assert property (@(posedge clock) disable iff (sys_rst)
      (st_q.loaded && clk_en && !gencall_reset && wr_valid && ack_fall && wr_chan[g])
      |=> st_q.vol[g] == $past(wr_cfg))
      else $error("write not committed at ack fall");
    chk_gencall_reload: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && gencall_reset) |=> st_q.vol[g] == $past(nv_cfg[g]))
      else $error("general call did not reload");
    chk_gain_status: assert property (@(posedge clock) disable iff (sys_rst)
      st_q.loaded |-> st_q.gs[`DRGC_GAIN0_POS + g] == st_q.vol[g].gain_bit)
      else $error("gain status bit misplaced");
    chk_gain_two: assert property (@(posedge clock) disable iff (sys_rst)
      st_q.ctl[g].amp_gain2 |-> (st_q.ctl[g].ladder_top_node[0] == 1'b0 && st_q.vol[g].gain_bit))
      else $error("gain two without cause");

    // the reference pin must stay off the ladder while the supply feeds it
    chk_supply_pin_open: assert property (@(posedge clock) disable iff (sys_rst)
      st_q.ctl[g].ladder_top_node[0]
      |-> (st_q.ctl[g].ladder_top_node[3:2] == 2'b00))
      else $error("reference pin connected with supply reference");

    // once loaded, the applied source follows the volatile select copy
    chk_applied_volatile: assert property (@(posedge clock) disable iff (sys_rst)
      st_q.loaded
      |-> (st_q.ctl[g].ladder_top_node == (4'h1 << st_q.vol[g].ref_source_select)))
      else $error("applied source differs from volatile select");

    // code 00 must land on the supply switch
    chk_code_supply: assert property (@(posedge clock) disable iff (sys_rst)
      (st_q.loaded && st_q.vol[g].ref_source_select == `DRGC_REF_SUPPLY)
      |-> (st_q.ctl[g].ladder_top_node == 4'h1))
      else $error("select 00 did not pick the supply");

    // code 01 must land on the bandgap switch
    chk_code_bandgap: assert property (@(posedge clock) disable iff (sys_rst)
      (st_q.loaded && st_q.vol[g].ref_source_select == `DRGC_REF_BANDGAP)
      |-> (st_q.ctl[g].ladder_top_node == 4'h2))
      else $error("select 01 did not pick the bandgap");

    // code 10 must land on the unbuffered pin switch
    chk_code_pin_unbuf: assert property (@(posedge clock) disable iff (sys_rst)
      (st_q.loaded && st_q.vol[g].ref_source_select == `DRGC_REF_PIN_UNBUF)
      |-> (st_q.ctl[g].ladder_top_node == 4'h4))
      else $error("select 10 did not pick the unbuffered pin");

    // code 11 must land on the buffered pin switch
    chk_code_pin_buf: assert property (@(posedge clock) disable iff (sys_rst)
      (st_q.loaded && st_q.vol[g].ref_source_select == `DRGC_REF_PIN_BUF)
      |-> (st_q.ctl[g].ladder_top_node == 4'h8))
      else $error("select 11 did not pick the buffered pin");

    // a cleared gain bit always means unity gain
    chk_gain_one: assert property (@(posedge clock) disable iff (sys_rst)
      (st_q.loaded && !st_q.vol[g].gain_bit)
      |-> !st_q.ctl[g].amp_gain2)
      else $error("gain two with gain bit cleared");

    // a set gain bit with a non-supply source must give double gain
    chk_gain_double: assert property (@(posedge clock) disable iff (sys_rst)
      (st_q.loaded && st_q.vol[g].gain_bit && st_q.vol[g].ref_source_select != `DRGC_REF_SUPPLY)
      |-> st_q.ctl[g].amp_gain2)
      else $error("gain two missing with gain bit set");

    // every power-down code turns the amplifier off
    chk_amp_off: assert property (@(posedge clock) disable iff (sys_rst)
      (st_q.loaded && st_q.vol[g].powerdown_select != `DRGC_PD_NORMAL)
      |-> !st_q.ctl[g].amp_enable)
      else $error("amplifier on in power-down");

    // normal mode drives the output pin
    chk_amp_on: assert property (@(posedge clock) disable iff (sys_rst)
      (st_q.loaded && st_q.vol[g].powerdown_select == `DRGC_PD_NORMAL)
      |-> (st_q.ctl[g].amp_enable && !st_q.ctl[g].out_hiz))
      else $error("amplifier off in normal mode");

    // enable and high impedance never agree once loaded
    chk_hiz_exclusive: assert property (@(posedge clock) disable iff (sys_rst)
      st_q.loaded
      |-> (st_q.ctl[g].amp_enable != st_q.ctl[g].out_hiz))
      else $error("amplifier enable and high impedance agree");

    // the wiper sees the raw unsigned code
    chk_wiper_code: assert property (@(posedge clock) disable iff (sys_rst)
      st_q.loaded
      |-> (st_q.ctl[g].wiper_code == st_q.vol[g].code))
      else $error("wiper code differs from volatile code");

    // a write without its ack pulse leaves the channel alone
    chk_refused_write: assert property (@(posedge clock) disable iff (sys_rst)
      (st_q.loaded && clk_en && !gencall_reset && wr_valid && !ack_fall)
      |=> $stable(st_q.vol[g]))
      else $error("write applied without ack fall");

    // a write aimed at the other channel leaves this one alone
    chk_other_chan: assert property (@(posedge clock) disable iff (sys_rst)
      (st_q.loaded && clk_en && !gencall_reset && !wr_chan[g])
      |=> $stable(st_q.vol[g]))
      else $error("write reached an unselected channel");

    // general call beats a write that lands in the same cycle
    chk_gencall_priority: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && gencall_reset && wr_valid && ack_fall)
      |=> (st_q.vol[g] == $past(nv_cfg[g])))
      else $error("write won over general call");

    // a low clock enable freezes the volatile copy
    chk_freeze_vol: assert property (@(posedge clock) disable iff (sys_rst)
      !clk_en
      |=> $stable(st_q.vol[g]))
      else $error("volatile copy moved while frozen");

    // a low clock enable freezes the analog controls too
    chk_freeze_ctl: assert property (@(posedge clock) disable iff (sys_rst)
      !clk_en
      |=> $stable(st_q.ctl[g]))
      else $error("analog controls moved while frozen");

    // controls move only when the volatile copy moves
    chk_ctl_follows: assert property (@(posedge clock) disable iff (sys_rst)
      (st_q.loaded && $past(st_q.loaded) && $stable(st_q.vol[g]))
      |-> $stable(st_q.ctl[g]))
      else $error("controls changed without a volatile change");

    // the gain status bit follows any gain change within the same edge
    chk_status_follow: assert property (@(posedge clock) disable iff (sys_rst)
      (st_q.loaded && $past(st_q.loaded))
      |-> ($changed(st_q.vol[g].gain_bit) == $changed(st_q.gs[`DRGC_GAIN0_POS + g])))
      else $error("gain status lagged the gain bit");
  end

  chk_first_load: assert property (@(posedge clock) disable iff (sys_rst)
    (!st_q.loaded && clk_en) |=> (st_q.loaded && st_q.vol == $past(nv_cfg)))
    else $error("stored values not loaded after reset");

  // low status bits belong to other fields and stay clear here
  chk_status_low: assert property (@(posedge clock) disable iff (sys_rst)
    st_q.loaded
    |-> (st_q.gs[`DRGC_GAIN0_POS-1:0] == '0))
    else $error("status bits below the gain field set");

  // bits above the last channel gain stay clear
  chk_status_high: assert property (@(posedge clock) disable iff (sys_rst)
    st_q.loaded
    |-> ((st_q.gs >> (`DRGC_GAIN0_POS + CHANNELS)) == '0))
    else $error("status bits above the gain field set");

  // ladder count matches one of the three resolution variants
  chk_ladder_count: assert property (@(posedge clock) disable iff (sys_rst)
    st_q.loaded
    |-> ((RES_BITS == 8 && st_q.lcount == `DRGC_LADDER_8BIT) ||
         (RES_BITS == 10 && st_q.lcount == `DRGC_LADDER_10BIT) ||
         (RES_BITS == 12 && st_q.lcount == `DRGC_LADDER_12BIT)))
    else $error("ladder count does not match resolution");

  // once loaded the block never falls back to unloaded without reset
  chk_stay_loaded: assert property (@(posedge clock) disable iff (sys_rst)
    st_q.loaded
    |=> st_q.loaded)
    else $error("loaded flag dropped without reset");

  // a freeze right after reset delays the first load
  chk_frozen_unloaded: assert property (@(posedge clock) disable iff (sys_rst)
    (!st_q.loaded && !clk_en)
    |=> !st_q.loaded)
    else $error("stored values loaded while frozen");

endmodule : drgc_core

/* File: test/dac_reference_gain_control_tb.sv */
// randomised bench for the reference, gain and output enable control
`timescale 1ns/1ps
module dac_reference_gain_control_tb import drgc_pkg::*;;
  logic clock = 0, sys_rst = 1, gc = 0, ce = 1, wv, af, a;
  logic [31:0] seed = 79133;
  int n_fail = 0, checked = 0, cyc = 0;
  drgc_chan_cfg_t [1:0] nv, ex;
  drgc_chan_ctl_t [1:0] ctl;
  drgc_chan_cfg_t wf, v;
  logic [15:0] gs, lc;
  logic [1:0] wc, c;
  always #2 clock = ~clock;
  drgc_host_model host_u (.clock(clock), .wr_valid(wv), .wr_chan(wc), .wr_cfg(wf), .ack_fall(af));
  drgc_core dut_u (.clock(clock), .sys_rst(sys_rst), .clk_en(ce), .nv_cfg(nv), .wr_valid(wv), .wr_chan(wc),
    .wr_cfg(wf), .ack_fall(af), .gencall_reset(gc), .chan_ctl(ctl), .gain_status(gs), .ladder_count(lc));
  // xorshift keeps the run repeatable
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // expected analog controls for one volatile setting
  function automatic drgc_chan_ctl_t exp_ctl(drgc_chan_cfg_t s);
    return {4'h1 << s.ref_source_select, s.gain_bit && s.ref_source_select != 0,
      s.powerdown_select == 0, s.powerdown_select != 0, s.code};
  endfunction : exp_ctl
  task automatic chk(string what, logic [63:0] seen, logic [63:0] want);
    checked++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : chk
  // both channels, gain status and ladder count against the model
  task automatic chk_all();
    @(negedge clock);
    chk("chan_ctl", 64'(ctl), 64'({exp_ctl(ex[1]), exp_ctl(ex[0])}));
    chk("gain_status", 64'(gs), 64'({6'h00, ex[1].gain_bit, ex[0].gain_bit, 8'h00}));
    chk("ladder_count", 64'(lc), 64'h1000);
  endtask : chk_all
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // hang guard, the tests need well under a thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    nv = 34'({rnd(), rnd()});
    repeat (8) @(negedge clock);
    sys_rst = 0;
    ex = nv;
    chk_all();
    $display("test reset recall done");
    // every select code with the gain bit set, on both channels
    for (int s = 0; s < 4; s++) begin
      ex[0] = {s[1:0], 1'b1, 2'b00, 12'(rnd())};
      ex[1] = ex[0];
      host_u.wr(2'b11, ex[0], 1'b1);
      chk_all();
    end
    $display("test select codes done");
    // random writes, some without ack, with random power-down
    for (int i = 0; i < 40; i++) begin
      c = 2'(rnd());
      v = 17'(rnd());
      a = 1'(rnd());
      host_u.wr(c, v, a);
      for (int k = 0; k < 2; k++) if (a && c[k]) ex[k] = v;
      chk_all();
    end
    $display("test random writes done");
    // a frozen block ignores even an acknowledged write
    ce = 0;
    host_u.wr(2'b11, ~ex[0], 1'b1);
    chk_all();
    ce = 1;
    $display("test clock enable hold done");
    // general call wins over a write in the same cycle
    gc = 1;
    host_u.wr(2'b11, ~nv[0], 1'b1);
    gc = 0;
    ex = nv;
    chk_all();
    $display("test general call done");
    summarize();
  end
endmodule : dac_reference_gain_control_tb

/* File: test/drgc_host_model.sv */
// serial host stand-in that commits decoded writes with an ack-fall pulse
`timescale 1ns/1ps
module drgc_host_model import drgc_pkg::*; (
  // write side toward the core
  input wire logic clock,
  output logic wr_valid,
  output logic [1:0] wr_chan,
  output drgc_chan_cfg_t wr_cfg,
  output logic ack_fall
);
  initial {wr_valid, wr_chan, wr_cfg, ack_fall} = '0;
  // one write; a missing ack pulse must leave the core untouched
  task automatic wr(input logic [1:0] c, input drgc_chan_cfg_t v, input logic a);
    @(negedge clock);
    {wr_valid, wr_chan, wr_cfg, ack_fall} = {1'b1, c, v, a};
    @(negedge clock);
    {wr_valid, ack_fall, wr_cfg} = {2'b00, ~v}; // released data shows the inverse
  endtask : wr
endmodule : drgc_host_model
